//--- hdl/fcs_switch.sv
// fail-safe clock switch with keyed oscillator control register
// assumes synchronous inputs, one 100 MHz clock and a classic wishbone master
`include "fcs_cfg.svh"

// ----------------------------------------------------------------------
// top module
// ----------------------------------------------------------------------
// How it works
// - monitor on keeps low-power RC running outside sleep
// - failure raises trap, moves clock to fast RC
// - failure loads fast RC, sets flag, clears enable
// - watchdog clock untouched by failure
// - power-up timeout before start counts as failure
// - only four groups are switch targets
// - primary option comes from primary select
// - read-only current group field shows live group
// - writable new group field names target
// - reset loads both group fields from config
// - lock bit reports pll lock
// - enable rises at start; clearing it aborts
// - config 1x disables switching and monitoring
// - switching off means config selects oscillator
// - low byte opens after keys 46 then 57
// - high byte opens after keys 78 then 9A
module fcs_switch
    import fcs_pkg::*;
(
    input  wire logic        CLK_SYS,
    input  wire logic        SRST,
    input  wire logic        WB_CYC_I,
    input  wire logic        WB_STB_I,
    input  wire logic        WB_WE_I,
    input  wire logic [3:0]  WB_ADR_I,
    input  wire logic [3:0]  WB_SEL_I,
    input  wire logic [31:0] WB_DAT_I,
    output logic      [31:0] WB_DAT_O,
    output logic             WB_ACK_O,
    input  wire logic [1:0]  CFG_SWITCH_MONITOR_SELECT,
    input  wire logic [2:0]  CFG_INITIAL_OSC_GROUP,
    input  wire logic [4:0]  CFG_PRIMARY_OSC_SELECT,
    input  wire logic [3:0]  OSC_ACTIVE,
    input  wire logic        PLL_LOCK,
    input  wire logic        POWER_UP_TIMER_DONE,
    input  wire logic        SLEEP,
    input  wire logic        SOFT_WATCHDOG_ENABLE,
    output logic      [2:0]  OSC_GROUP_SEL,
    output logic      [4:0]  PRIMARY_OSC_SELECT,
    output logic      [3:0]  OSC_ENABLE,
    output logic             LOW_POWER_RC_RUN,
    output logic             CLOCK_FAIL_TRAP,
    output logic             IRQ
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    fcs_ctrl_t   ctrl_reg;
    fcs_ctrl_t   ctrl_next;
    fcs_state_t  state_reg;
    fcs_state_t  state_next;
    fcs_unlock_t unl_lo_reg;
    fcs_unlock_t unl_lo_next;
    fcs_unlock_t unl_hi_reg;
    fcs_unlock_t unl_hi_next;
    logic [1:0]  irq_stat_reg;
    logic [1:0]  irq_en_reg;
    logic [15:0] fail_cnt_reg;
    logic        trap_reg;
    logic        ack_reg;
    logic [31:0] rdata_reg;
    logic        power_up_timer_wait_reg;

    // ------------------------------------------------------------------
    // group helpers
    // ------------------------------------------------------------------
    function automatic logic grp_valid(input logic [2:0] g);
        grp_valid = (g == `FCS_GRP_SEC) || (g == `FCS_GRP_FRC) ||
                    (g == `FCS_GRP_LOW_POWER_RC_OSC) || (g == `FCS_GRP_PRI);
    endfunction : grp_valid

    function automatic logic [3:0] grp_onehot(input logic [2:0] g);
        grp_onehot = 4'h0;
        case (g)
            `FCS_GRP_SEC:  grp_onehot[`FCS_IDX_SEC]  = 1'b1;
            `FCS_GRP_FRC:  grp_onehot[`FCS_IDX_FRC]  = 1'b1;
            `FCS_GRP_LOW_POWER_RC_OSC: grp_onehot[`FCS_IDX_LOW_POWER_RC_OSC] = 1'b1;
            `FCS_GRP_PRI:  grp_onehot[`FCS_IDX_PRI]  = 1'b1;
            default:       grp_onehot[`FCS_IDX_FRC]  = 1'b1;
        endcase
    endfunction : grp_onehot

    // ------------------------------------------------------------------
    // configuration decode
    // ------------------------------------------------------------------
    wire switch_en  = ~CFG_SWITCH_MONITOR_SELECT[1];
    wire monitor_en = (CFG_SWITCH_MONITOR_SELECT == 2'h0);
    wire [3:0] cur_oh  = grp_onehot(ctrl_reg.current_osc_group);
    wire [3:0] new_oh  = grp_onehot(ctrl_reg.new_osc_group);
    wire       cur_act = |(cur_oh & OSC_ACTIVE);
    wire       new_act = |(new_oh & OSC_ACTIVE);

    // ------------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------------
    wire bus_req  = WB_CYC_I & WB_STB_I & ~ack_reg;
    wire bus_wr   = bus_req & WB_WE_I;
    wire hit_ctrl = (WB_ADR_I == `FCS_OFF_CTRL);
    wire hit_stat = (WB_ADR_I == `FCS_OFF_IRQ_STAT);
    wire hit_clr  = (WB_ADR_I == `FCS_OFF_IRQ_CLR);
    wire hit_en   = (WB_ADR_I == `FCS_OFF_IRQ_EN);
    wire wr_lo    = bus_wr & hit_ctrl & WB_SEL_I[0];
    wire wr_hi    = bus_wr & hit_ctrl & WB_SEL_I[1];
    wire [7:0] dlo = WB_DAT_I[7:0];
    wire [7:0] dhi = WB_DAT_I[15:8];
    wire lo_commit = wr_lo & (unl_lo_reg == FCS_UNL_OPEN);
    wire hi_commit = wr_hi & (unl_hi_reg == FCS_UNL_OPEN);
    wire [15:0] ctrl_view = {1'b0, ctrl_reg.current_osc_group, 1'b0,
                             ctrl_reg.new_osc_group, 2'h0, ctrl_reg.pll_lock,
                             1'b0, ctrl_reg.clock_fail_flag, 2'h0,
                             ctrl_reg.osc_switch_enable};
    wire [31:0] rd_mux = hit_ctrl ? {16'h0000, ctrl_view} :
                         hit_stat ? {30'h0, irq_stat_reg} :
                         hit_en   ? {30'h0, irq_en_reg} : 32'h0000_0000;

    // ------------------------------------------------------------------
    // unlock sequence trackers
    // ------------------------------------------------------------------
    always_comb begin
        unl_lo_next = unl_lo_reg;
        if (bus_req) begin
            if (!wr_lo || lo_commit) begin
                unl_lo_next = FCS_UNL_NONE;
            end else if (unl_lo_reg == FCS_UNL_KEY1 && dlo == `FCS_KEY_LO_B) begin
                unl_lo_next = FCS_UNL_OPEN;
            end else if (dlo == `FCS_KEY_LO_A) begin
                unl_lo_next = FCS_UNL_KEY1;
            end else begin
                unl_lo_next = FCS_UNL_NONE;
            end
        end
    end

    always_comb begin
        unl_hi_next = unl_hi_reg;
        if (bus_req) begin
            if (!wr_hi || hi_commit) begin
                unl_hi_next = FCS_UNL_NONE;
            end else if (unl_hi_reg == FCS_UNL_KEY1 && dhi == `FCS_KEY_HI_B) begin
                unl_hi_next = FCS_UNL_OPEN;
            end else if (dhi == `FCS_KEY_HI_A) begin
                unl_hi_next = FCS_UNL_KEY1;
            end else begin
                unl_hi_next = FCS_UNL_NONE;
            end
        end
    end

    // ------------------------------------------------------------------
    // failure detection
    // ------------------------------------------------------------------
    wire fail_timeout = (fail_cnt_reg >= 16'(`FCS_FAIL_CYCLES));
    wire power_up_timer_fail    = power_up_timer_wait_reg & POWER_UP_TIMER_DONE & ~cur_act;
    wire fail_evt     = monitor_en & ~SLEEP & ~trap_reg &
                        (fail_timeout | power_up_timer_fail);
    wire switch_done  = (state_reg == FCS_SWITCH) & ctrl_reg.osc_switch_enable &
                        new_act & ~fail_evt;

    // ------------------------------------------------------------------
    // control register and switch sequencer
    // ------------------------------------------------------------------
    always_comb begin
        ctrl_next = ctrl_reg;
        state_next = state_reg;
        ctrl_next.pll_lock = PLL_LOCK;
        if (hi_commit) begin
            ctrl_next.new_osc_group = dhi[`FCS_NEW_HI-8:`FCS_NEW_LO-8];
        end
        if (lo_commit) begin
            ctrl_next.osc_switch_enable = dlo[`FCS_SWEN_BIT];
        end
        case (state_reg)
            FCS_IDLE: begin
                if (ctrl_reg.osc_switch_enable) begin
                    if (switch_en && grp_valid(ctrl_reg.new_osc_group) &&
                        ctrl_reg.new_osc_group != ctrl_reg.current_osc_group) begin
                        state_next = FCS_SWITCH;
                    end else begin
                        ctrl_next.osc_switch_enable = 1'b0;
                    end
                end
            end
            FCS_SWITCH: begin
                if (!ctrl_reg.osc_switch_enable) begin
                    state_next = FCS_IDLE;
                end else if (new_act) begin
                    ctrl_next.current_osc_group = ctrl_reg.new_osc_group;
                    ctrl_next.osc_switch_enable = 1'b0;
                    state_next = FCS_IDLE;
                end
            end
            default: begin
                state_next = FCS_IDLE;
            end
        endcase
        if (!switch_en) begin
            ctrl_next.current_osc_group = CFG_INITIAL_OSC_GROUP;
            state_next = FCS_IDLE;
        end
        if (fail_evt) begin
            ctrl_next.current_osc_group = `FCS_GRP_FRC;
            ctrl_next.clock_fail_flag = 1'b1;
            ctrl_next.osc_switch_enable = 1'b0;
            state_next = FCS_IDLE;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            ctrl_reg <= '{CFG_INITIAL_OSC_GROUP, CFG_INITIAL_OSC_GROUP,
                          1'b0, 1'b0, 1'b0};
            state_reg <= FCS_IDLE;
            unl_lo_reg <= FCS_UNL_NONE;
            unl_hi_reg <= FCS_UNL_NONE;
        end else begin
            ctrl_reg <= ctrl_next;
            state_reg <= state_next;
            unl_lo_reg <= unl_lo_next;
            unl_hi_reg <= unl_hi_next;
        end
    end

    // ------------------------------------------------------------------
    // monitor counters and trap
    // ------------------------------------------------------------------
    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            fail_cnt_reg <= 16'h0000;
            trap_reg <= 1'b0;
            power_up_timer_wait_reg <= 1'b1;
        end else begin
            trap_reg <= fail_evt;
            if (POWER_UP_TIMER_DONE || SLEEP) begin
                power_up_timer_wait_reg <= SLEEP;
            end
            if (!monitor_en || SLEEP || cur_act || fail_evt) begin
                fail_cnt_reg <= 16'h0000;
            end else if (!fail_timeout) begin
                fail_cnt_reg <= fail_cnt_reg + 16'h0001;
            end
        end
    end

    // ------------------------------------------------------------------
    // interrupt status, clear and enable
    // ------------------------------------------------------------------
    wire [1:0] irq_set = {switch_done, fail_evt};
    wire [1:0] irq_clr = (bus_wr & hit_clr & WB_SEL_I[0]) ? WB_DAT_I[1:0] : 2'h0;

    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            irq_stat_reg <= `FCS_IRQ_RESET;
            irq_en_reg <= `FCS_IRQ_RESET;
        end else begin
            irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_set;
            if (bus_wr && hit_en && WB_SEL_I[0]) begin
                irq_en_reg <= WB_DAT_I[1:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // wishbone answer
    // ------------------------------------------------------------------
    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            ack_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
        end else begin
            ack_reg <= bus_req;
            if (bus_req) begin
                rdata_reg <= WB_WE_I ? 32'h0000_0000 : rd_mux;
            end
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    wire low_power_rc_osc_keep = monitor_en ? ~SLEEP : SOFT_WATCHDOG_ENABLE;

    assign WB_ACK_O = ack_reg;
    assign WB_DAT_O = rdata_reg;
    assign IRQ = |(irq_stat_reg & irq_en_reg);
    assign CLOCK_FAIL_TRAP = trap_reg;
    assign OSC_GROUP_SEL = ctrl_reg.current_osc_group;
    assign PRIMARY_OSC_SELECT = (ctrl_reg.current_osc_group == `FCS_GRP_PRI) ?
                                CFG_PRIMARY_OSC_SELECT : 5'h00;
    assign LOW_POWER_RC_RUN = low_power_rc_osc_keep;
    assign OSC_ENABLE = cur_oh | ((state_reg == FCS_SWITCH) ? new_oh : 4'h0) |
                        {1'b0, low_power_rc_osc_keep, 2'h0};

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (SRST);

    low_power_rc_osc_kept_on_a: assert property (monitor_en && !SLEEP |-> LOW_POWER_RC_RUN)
        else $error("low-power rc stopped while monitored");
    fail_trap_a: assert property (fail_evt |=> CLOCK_FAIL_TRAP &&
                                  OSC_GROUP_SEL == `FCS_GRP_FRC)
        else $error("failure did not trap to fast rc");
    fail_fields_a: assert property (fail_evt |=> ctrl_reg.clock_fail_flag &&
                                    !ctrl_reg.osc_switch_enable)
        else $error("failure fields not updated");
    power_up_timer_fail_a: assert property (monitor_en && !SLEEP && !trap_reg && power_up_timer_fail
                                  |=> CLOCK_FAIL_TRAP)
        else $error("power-up timeout not treated as failure");
    switch_legal_a: assert property (state_reg == FCS_SWITCH |->
                                     grp_valid(ctrl_reg.new_osc_group))
        else $error("switch toward invalid group");
    prim_sel_a: assert property (OSC_GROUP_SEL == `FCS_GRP_PRI |->
                                 PRIMARY_OSC_SELECT == CFG_PRIMARY_OSC_SELECT)
        else $error("primary option not from config");
    abort_a: assert property (state_reg == FCS_SWITCH && !ctrl_reg.osc_switch_enable &&
                              switch_en && !fail_evt |=> state_reg == FCS_IDLE &&
                              $stable(ctrl_reg.current_osc_group))
        else $error("abort did not stop switch");
    no_switch_a: assert property (!switch_en |=> state_reg == FCS_IDLE &&
                                  !CLOCK_FAIL_TRAP)
        else $error("disabled config still switched");
    lo_guard_a: assert property (wr_lo && unl_lo_reg != FCS_UNL_OPEN &&
                                 !ctrl_reg.osc_switch_enable |=>
                                 !ctrl_reg.osc_switch_enable)
        else $error("locked low byte changed");
    hi_guard_a: assert property (!hi_commit |=> $stable(ctrl_reg.new_osc_group))
        else $error("locked high byte changed");
    ack_one_a: assert property (WB_ACK_O |=> !WB_ACK_O)
        else $error("ack held two cycles");

    switch_done_c: cover property (state_reg == FCS_SWITCH ##1 state_reg == FCS_IDLE);
    fail_c: cover property (fail_evt);
    unlock_lo_c: cover property (lo_commit);
    unlock_hi_c: cover property (hi_commit);

endmodule : fcs_switch

//--- inc/fcs_cfg.svh
// register offsets, field positions, reset values, keys and timing counts
// assumes a 100 MHz system clock and a 4-bit wishbone byte address
`ifndef FCS_CFG_SVH
`define FCS_CFG_SVH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define FCS_OFF_CTRL        4'h0
`define FCS_OFF_IRQ_STAT    4'h4
`define FCS_OFF_IRQ_CLR     4'h8
`define FCS_OFF_IRQ_EN      4'hC

// ----------------------------------------------------------------------
// oscillator control fields
// ----------------------------------------------------------------------
`define FCS_CUR_HI          14
`define FCS_CUR_LO          12
`define FCS_NEW_HI          10
`define FCS_NEW_LO          8
`define FCS_LOCK_BIT        5
`define FCS_CF_BIT          3
`define FCS_SWEN_BIT        0
`define FCS_IRQ_FAIL_BIT    0
`define FCS_IRQ_DONE_BIT    1
`define FCS_IRQ_RESET       2'h0

// ----------------------------------------------------------------------
// unlock keys
// ----------------------------------------------------------------------
`define FCS_KEY_LO_A        8'h46
`define FCS_KEY_LO_B        8'h57
`define FCS_KEY_HI_A        8'h78
`define FCS_KEY_HI_B        8'h9A

// ----------------------------------------------------------------------
// oscillator group codes and index positions
// ----------------------------------------------------------------------
`define FCS_GRP_SEC         3'h0
`define FCS_GRP_FRC         3'h1
`define FCS_GRP_LOW_POWER_RC_OSC        3'h2
`define FCS_GRP_PRI         3'h3
`define FCS_IDX_SEC         0
`define FCS_IDX_FRC         1
`define FCS_IDX_LOW_POWER_RC_OSC        2
`define FCS_IDX_PRI         3

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define FCS_CLK_MHZ         100
`define FCS_FAIL_TIME_NS    2000
`define FCS_FAIL_CYCLES     ((`FCS_FAIL_TIME_NS * `FCS_CLK_MHZ) / 1000)

`endif

//--- inc/fcs_pkg.sv
// types of the fail-safe clock switch
// assumes fcs_cfg.svh for all numbers
package fcs_pkg;

    typedef enum logic [1:0] {
        FCS_IDLE,
        FCS_SWITCH
    } fcs_state_t;

    typedef struct packed {
        logic [2:0] current_osc_group;
        logic [2:0] new_osc_group;
        logic       pll_lock;
        logic       clock_fail_flag;
        logic       osc_switch_enable;
    } fcs_ctrl_t;

    typedef enum logic [1:0] {
        FCS_UNL_NONE,
        FCS_UNL_KEY1,
        FCS_UNL_OPEN
    } fcs_unlock_t;

endpackage : fcs_pkg

//--- sim/fcs_osc_model.sv
// ----------------------------------------------------------------------
// oscillator sources model
// ----------------------------------------------------------------------
// four oscillator groups that start some cycles after being enabled
// assumes the bench may kill a group to fake a failed oscillator
`include "fcs_cfg.svh"
module fcs_osc_model #(
    parameter int START_CYC = 20
) (
    input  wire logic       clk,
    input  wire logic [3:0] osc_enable,
    input  wire logic [3:0] kill,
    output logic      [3:0] osc_active,
    output logic            pll_lock
);
    timeunit 1ns;
    timeprecision 1ps;

    int cnt [4];

    // start-up counter per group, cleared when disabled or killed
    always_ff @(posedge clk) begin
        for (int i = 0; i < 4; i++) begin
            if (!osc_enable[i] || kill[i]) begin
                cnt[i] <= 0;
            end else if (cnt[i] < START_CYC) begin
                cnt[i] <= cnt[i] + 1;
            end
        end
    end

    always_comb begin
        for (int i = 0; i < 4; i++) begin
            osc_active[i] = (cnt[i] == START_CYC);
        end
    end

    assign pll_lock = osc_active[`FCS_IDX_PRI];
endmodule : fcs_osc_model

//--- sim/fcs_switch_tb.sv
// ----------------------------------------------------------------------
// self-checking bench of the fail-safe clock switch
// ----------------------------------------------------------------------
// assumes fcs_switch, fcs_osc_model and fcs_cfg.svh on the include path
`include "fcs_cfg.svh"
module fcs_switch_tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic        CLK_SYS, SRST, WB_CYC_I, WB_STB_I, WB_WE_I, WB_ACK_O, PLL_LOCK, SLEEP, IRQ;
    logic        POWER_UP_TIMER_DONE, SOFT_WATCHDOG_ENABLE, LOW_POWER_RC_RUN, CLOCK_FAIL_TRAP;
    logic [3:0]  WB_ADR_I, WB_SEL_I, OSC_ACTIVE, OSC_ENABLE, kill;
    logic [31:0] WB_DAT_I, WB_DAT_O, rd;
    logic [1:0]  CFG_SWITCH_MONITOR_SELECT;
    logic [2:0]  CFG_INITIAL_OSC_GROUP, OSC_GROUP_SEL, tgt;
    logic [4:0]  CFG_PRIMARY_OSC_SELECT, PRIMARY_OSC_SELECT;
    int          fail_count, compares, n;

    fcs_switch dut_u (
        .CLK_SYS(CLK_SYS), .SRST(SRST), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
        .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I),
        .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O),
        .CFG_SWITCH_MONITOR_SELECT(CFG_SWITCH_MONITOR_SELECT),
        .CFG_INITIAL_OSC_GROUP(CFG_INITIAL_OSC_GROUP),
        .CFG_PRIMARY_OSC_SELECT(CFG_PRIMARY_OSC_SELECT), .OSC_ACTIVE(OSC_ACTIVE),
        .PLL_LOCK(PLL_LOCK), .POWER_UP_TIMER_DONE(POWER_UP_TIMER_DONE), .SLEEP(SLEEP),
        .SOFT_WATCHDOG_ENABLE(SOFT_WATCHDOG_ENABLE), .OSC_GROUP_SEL(OSC_GROUP_SEL),
        .PRIMARY_OSC_SELECT(PRIMARY_OSC_SELECT), .OSC_ENABLE(OSC_ENABLE),
        .LOW_POWER_RC_RUN(LOW_POWER_RC_RUN), .CLOCK_FAIL_TRAP(CLOCK_FAIL_TRAP), .IRQ(IRQ)
    );

    fcs_osc_model osc_u (
        .clk(CLK_SYS), .osc_enable(OSC_ENABLE), .kill(kill),
        .osc_active(OSC_ACTIVE), .pll_lock(PLL_LOCK)
    );

    // ----------------------------------------------------------------------
    // tasks and expectations
    // ----------------------------------------------------------------------
    task automatic results();
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : results

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask : chk

    // classic cycle: held until ack is sampled high, then released
    task automatic wb(input logic we, input logic [3:0] adr, input logic [3:0] sel,
                      input logic [31:0] dat);
        int k;
        k = 0;
        @(posedge CLK_SYS);
        WB_CYC_I <= 1'b1;
        WB_STB_I <= 1'b1;
        WB_WE_I  <= we;
        WB_ADR_I <= adr;
        WB_SEL_I <= sel;
        WB_DAT_I <= dat;
        do begin
            @(posedge CLK_SYS);
            k++;
        end while (WB_ACK_O !== 1'b1 && k < 50);
        if (k >= 50) begin
            fail_count++;
            $display("BAD %0t no ack", $time);
        end
        rd = WB_DAT_O;
        WB_CYC_I <= 1'b0;
        WB_STB_I <= 1'b0;
    endtask : wb

    task automatic wr(input logic [3:0] sel, input logic [7:0] v);
        wb(1'b1, `FCS_OFF_CTRL, sel, sel[1] ? {16'h0000, v, 8'h00} : {24'h000000, v});
    endtask : wr

    task automatic rdc();
        wb(1'b0, `FCS_OFF_CTRL, 4'hF, 32'h0);
    endtask : rdc

    function automatic logic [31:0] ctrl(input logic [2:0] cur, input logic [2:0] nw,
                                         input logic cf, input logic sw);
        ctrl = 32'h0;
        ctrl[`FCS_CUR_HI:`FCS_CUR_LO] = cur;
        ctrl[`FCS_NEW_HI:`FCS_NEW_LO] = nw;
        ctrl[`FCS_LOCK_BIT] = PLL_LOCK;
        ctrl[`FCS_CF_BIT] = cf;
        ctrl[`FCS_SWEN_BIT] = sw;
    endfunction : ctrl

    // ----------------------------------------------------------------------
    // clock, watchdog, tests
    // ----------------------------------------------------------------------
    initial begin
        CLK_SYS = 1'b0;
        forever #5 CLK_SYS = ~CLK_SYS;
    end

    initial begin
        #200000;
        fail_count++;
        results();
    end

    initial begin
        void'($urandom(32'h732F2A64));
        {SRST, WB_CYC_I, WB_STB_I, WB_WE_I, SLEEP, POWER_UP_TIMER_DONE} = 6'h20;
        {WB_ADR_I, WB_SEL_I, kill, WB_DAT_I} = 44'h0;
        CFG_SWITCH_MONITOR_SELECT = 2'h0;
        CFG_INITIAL_OSC_GROUP = `FCS_GRP_PRI;
        CFG_PRIMARY_OSC_SELECT = 5'($urandom_range(31));
        SOFT_WATCHDOG_ENABLE = 1'($urandom_range(1));
        repeat (16) @(posedge CLK_SYS);
        SRST <= 1'b0;
        repeat (40) @(posedge CLK_SYS);
        POWER_UP_TIMER_DONE <= 1'b1;
        rdc();
        chk(rd, ctrl(`FCS_GRP_PRI, `FCS_GRP_PRI, 1'b0, 1'b0));
        chk({27'h0, PRIMARY_OSC_SELECT}, {27'h0, CFG_PRIMARY_OSC_SELECT});
        $display("test reset done");
        tgt = 3'($urandom_range(1));
        wr(4'h1, `FCS_KEY_LO_A);
        wr(4'h1, 8'h58);
        wr(4'h1, 8'h01);
        wr(4'h2, `FCS_KEY_HI_A);
        rdc();
        wr(4'h2, `FCS_KEY_HI_B);
        wr(4'h2, {5'h00, tgt});
        rdc();
        chk(rd, ctrl(`FCS_GRP_PRI, `FCS_GRP_PRI, 1'b0, 1'b0));
        wr(4'h2, `FCS_KEY_HI_A);
        wr(4'h2, `FCS_KEY_HI_B);
        wr(4'h2, {5'h00, tgt});
        wr(4'h1, `FCS_KEY_LO_A);
        wr(4'h1, `FCS_KEY_LO_B);
        wr(4'h1, 8'h01);
        rdc();
        chk(rd, ctrl(`FCS_GRP_PRI, tgt, 1'b0, 1'b1));
        n = 0;
        do begin
            rdc();
            n++;
        end while (rd[`FCS_SWEN_BIT] !== 1'b0 && n < 40);
        rdc();
        chk(rd, ctrl(tgt, tgt, 1'b0, 1'b0));
        chk({29'h0, OSC_GROUP_SEL}, {29'h0, tgt});
        wb(1'b1, `FCS_OFF_IRQ_EN, 4'hF, 32'h3);
        wb(1'b0, `FCS_OFF_IRQ_STAT, 4'hF, 32'h0);
        chk({rd[31:1], IRQ}, 32'h3);
        wb(1'b1, `FCS_OFF_IRQ_CLR, 4'hF, 32'h2);
        wb(1'b0, `FCS_OFF_IRQ_STAT, 4'hF, 32'h0);
        chk({rd[31:1], IRQ}, 32'h0);
        $display("test switch done");
        kill <= 4'h1 << tgt;
        n = 0;
        while (CLOCK_FAIL_TRAP !== 1'b1 && n < 400) begin
            @(posedge CLK_SYS);
            n++;
        end
        kill <= 4'h0;
        chk({31'h0, CLOCK_FAIL_TRAP}, 32'h1);
        chk({31'h0, LOW_POWER_RC_RUN}, 32'h1);
        rdc();
        chk(rd & 32'hFFFFF8FF, ctrl(`FCS_GRP_FRC, 3'h0, 1'b1, 1'b0));
        chk({29'h0, OSC_GROUP_SEL}, {29'h0, `FCS_GRP_FRC});
        wb(1'b0, `FCS_OFF_IRQ_STAT, 4'hF, 32'h0);
        chk({rd[31:1], IRQ}, 32'h1);
        wb(1'b1, `FCS_OFF_IRQ_EN, 4'hF, 32'h0);
        chk({31'h0, IRQ}, 32'h0);
        SLEEP <= 1'b1;
        repeat (2) @(posedge CLK_SYS);
        chk({31'h0, LOW_POWER_RC_RUN}, 32'h0);
        SLEEP <= 1'b0;
        $display("test failure done");
        kill <= 4'h1;
        wr(4'h2, `FCS_KEY_HI_A);
        wr(4'h2, `FCS_KEY_HI_B);
        wr(4'h2, {5'h00, `FCS_GRP_SEC});
        wr(4'h1, `FCS_KEY_LO_A);
        wr(4'h1, `FCS_KEY_LO_B);
        wr(4'h1, 8'h01);
        rdc();
        chk(rd, ctrl(`FCS_GRP_FRC, `FCS_GRP_SEC, 1'b1, 1'b1));
        wr(4'h1, `FCS_KEY_LO_A);
        wr(4'h1, `FCS_KEY_LO_B);
        wr(4'h1, 8'h00);
        rdc();
        chk(rd, ctrl(`FCS_GRP_FRC, `FCS_GRP_SEC, 1'b1, 1'b0));
        $display("test abort done");
        CFG_SWITCH_MONITOR_SELECT <= 2'h2;
        kill <= 4'hF;
        n = 0;
        repeat (4) begin
            CFG_INITIAL_OSC_GROUP <= 3'($urandom_range(3));
            repeat (80) begin
                @(posedge CLK_SYS);
                n += int'(CLOCK_FAIL_TRAP === 1'b1);
            end
            chk({29'h0, OSC_GROUP_SEL}, {29'h0, CFG_INITIAL_OSC_GROUP});
            chk({28'h0, OSC_ENABLE}, {28'h0, 4'h1 << CFG_INITIAL_OSC_GROUP} |
                {29'h0, SOFT_WATCHDOG_ENABLE, 2'h0});
        end
        chk(n, 32'h0);
        chk({31'h0, LOW_POWER_RC_RUN}, {31'h0, SOFT_WATCHDOG_ENABLE});
        $display("test switching off done");
        CFG_SWITCH_MONITOR_SELECT <= 2'h0;
        kill <= 4'h0;
        CFG_INITIAL_OSC_GROUP <= 3'($urandom_range(1));
        SRST <= 1'b1;
        POWER_UP_TIMER_DONE <= 1'b0;
        repeat (16) @(posedge CLK_SYS);
        SRST <= 1'b0;
        rdc();
        chk(rd, ctrl(CFG_INITIAL_OSC_GROUP, CFG_INITIAL_OSC_GROUP, 1'b0, 1'b0));
        $display("test second reset done");
        SRST <= 1'b1;
        kill <= 4'h8;
        CFG_INITIAL_OSC_GROUP <= `FCS_GRP_PRI;
        repeat (16) @(posedge CLK_SYS);
        SRST <= 1'b0;
        repeat (4) @(posedge CLK_SYS);
        POWER_UP_TIMER_DONE <= 1'b1;
        repeat (2) @(posedge CLK_SYS);
        chk({31'h0, CLOCK_FAIL_TRAP}, 32'h1);
        chk({29'h0, OSC_GROUP_SEL}, {29'h0, `FCS_GRP_FRC});
        kill <= 4'h0;
        $display("test power-up timeout done");
        results();
    end
endmodule : fcs_switch_tb
